// ===== logic/acs_seq.sv
// Purpose: start selection, busy, completion flag and tracking of an 8-bit SAR converter
// Assumes: timer overflows are one-cycle pulses on mclk_in; convert-start is an async pin
// Notes: registers on Avalon-MM; reads take two cycles, writes one
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "acs_map.svh"
module acs_seq (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Start sources and chip sleep
	input wire logic tmr2_ovf_in,
	input wire logic tmr3_ovf_in,
	input wire logic ext_start_in,
	input wire logic other_busy_wr_in,
	input wire logic sleep_in,
	// Analog core and interrupt
	input wire logic [7:0] sar_result_in,
	output acs_pkg::acs_analog_s analog_out,
	output logic irq_out
);
	import acs_pkg::*;

	acs_state_s s_q; // All registered state
	acs_state_s s_d; // Next state
	logic tick; // One converter-clock enable
	logic start; // Selected start event
	logic cnv_rise; // Synchronised external edge
	logic wr_ctrl; // Write strobe to control word
	logic [7:0] ctrl_rd; // Control word as read

	// Decode of an address match for one register
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	// Read mux shared by the response path
	always_comb begin
		// A latched start already reads busy, so a poll straight after the start write sees 1
		ctrl_rd = {s_q.en, s_q.tm, s_q.flag, (s_q.phase != ACS_IDLE || s_q.pend), s_q.ie, s_q.cm};
	end

	// Next-state logic
	always_comb begin
		s_d = s_q;
		wr_ctrl = avs_write_in && hit(avs_address_in, `ACS_OFF_CTRL);
		// Divider: tick once every sc+1 system clocks
		// divide by field plus one
		tick = (s_q.div == 5'h00);
		s_d.div = tick ? s_q.sc : 5'(s_q.div - 5'h01);
		// Pin passes two flops before the edge detector reads the second
		s_d.cnv_sync = {s_q.cnv_sync[0], ext_start_in};
		s_d.cnv_prev = s_q.cnv_sync[1];
		cnv_rise = s_q.cnv_sync[1] && !s_q.cnv_prev;
		// at most one source by mode field; reserved codes select none
		case (s_q.cm)
			ACS_SRC_SW: start = wr_ctrl && avs_writedata_in[`ACS_CTRL_BUSY];
			ACS_SRC_TMR3: start = tmr3_ovf_in;
			ACS_SRC_EXT: start = cnv_rise;
			ACS_SRC_TMR2: start = tmr2_ovf_in;
			ACS_SRC_JOINT: start = other_busy_wr_in;
			default: start = 1'b0;
		endcase
		start = start && s_q.en;
		// Register writes; one-cycle answer
		if (wr_ctrl) begin
			s_d.en = avs_writedata_in[`ACS_CTRL_EN];
			s_d.tm = avs_writedata_in[`ACS_CTRL_TM];
			s_d.flag = avs_writedata_in[`ACS_CTRL_INT];
			s_d.ie = avs_writedata_in[`ACS_CTRL_IE];
			s_d.cm = avs_writedata_in[`ACS_CTRL_CM_HI:`ACS_CTRL_CM_LO];
		end
		if (avs_write_in && hit(avs_address_in, `ACS_OFF_CFG)) begin
			s_d.sc = avs_writedata_in[`ACS_CFG_SC_HI:`ACS_CFG_SC_LO];
			s_d.gain = avs_writedata_in[`ACS_CFG_GN_HI:`ACS_CFG_GN_LO];
		end
		if (avs_write_in && hit(avs_address_in, `ACS_OFF_CHAN)) begin
			s_d.chan = avs_writedata_in[2:0];
		end
		// Start latches until the next converter tick
		if (start && s_q.phase == ACS_IDLE) begin
			s_d.pend = 1'b1;
		end
		// Sequencer
		case (s_q.phase)
			ACS_IDLE: begin
				if (s_q.pend && tick) begin
					s_d.pend = 1'b0;
					s_d.phase = (s_q.tm && s_q.cm != ACS_SRC_EXT) ? ACS_TRACK : ACS_CONV;
					s_d.cnt = (s_q.tm && s_q.cm != ACS_SRC_EXT) ? `ACS_TRACK_CLKS : `ACS_CONV_CLKS;
				end
			end
			ACS_TRACK: begin
				if (tick) begin
					s_d.cnt = 4'(s_q.cnt - 4'h1);
					if (s_q.cnt == 4'h1) begin
						s_d.phase = ACS_CONV;
						s_d.cnt = `ACS_CONV_CLKS;
					end
				end
			end
			ACS_CONV: begin
				if (tick) begin
					s_d.cnt = 4'(s_q.cnt - 4'h1);
					if (s_q.cnt == 4'h1) begin
						s_d.phase = ACS_IDLE;
						s_d.data = sar_result_in;
						s_d.flag = 1'b1;
					end
				end
			end
			default: s_d.phase = ACS_IDLE;
		endcase
		// Disabling aborts any conversion
		if (!s_d.en) begin
			s_d.phase = ACS_IDLE;
			s_d.pend = 1'b0;
		end
		s_d.irq = s_d.flag && s_d.ie;
		// Read response: one wait cycle then data
		s_d.rd_wait = avs_read_in && !s_q.rd_wait;
		if (avs_read_in && !s_q.rd_wait) begin
			if (hit(avs_address_in, `ACS_OFF_CTRL)) begin
				s_d.rdata = {24'h000000, ctrl_rd};
			end else if (hit(avs_address_in, `ACS_OFF_CFG)) begin
				s_d.rdata = {24'h000000, s_q.sc, 1'b0, s_q.gain};
			end else if (hit(avs_address_in, `ACS_OFF_CHAN)) begin
				s_d.rdata = {29'h00000000, s_q.chan};
			end else if (hit(avs_address_in, `ACS_OFF_DATA)) begin
				s_d.rdata = {24'h000000, s_q.data};
			end else begin
				s_d.rdata = 32'h00000000;
			end
		end
		s_d.ana.power_on = s_d.en;
		if (!s_d.en || sleep_in) begin
			s_d.ana.track = 1'b0;
		end else if (s_d.tm) begin
			// Phase is the current one, so track lines up with the converter clock pulses
			s_d.ana.track = (s_q.phase == ACS_TRACK) ||
				(s_d.cm == ACS_SRC_EXT && s_q.phase == ACS_IDLE && !s_q.cnv_sync[1]);
		end else begin
			// Track stays low through the final tick; tracking resumes one cycle later
			// Trade-off: one cycle of lost tracking against a clean hold edge
			s_d.ana.track = (s_q.phase != ACS_CONV);
		end
		s_d.ana.channel = s_d.chan;
		s_d.ana.gain = s_d.gain;
		s_d.ana.sar_clk_en = tick && (s_q.phase == ACS_CONV);
		s_d.ana.sample = (s_q.phase == ACS_CONV) && tick && (s_q.cnt == 4'h1);
	end

	// Single state register
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= '0;
			// gain 0.5 and divider all ones after reset
			s_q.sc <= 5'(`ACS_CFG_RST >> `ACS_CFG_SC_LO);
			s_q.gain <= 2'h0;
			s_q.phase <= ACS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata_out = s_q.rdata;
	assign avs_waitrequest_out = avs_read_in && !s_q.rd_wait;
	assign analog_out = s_q.ana;
	assign irq_out = s_q.irq;

	// Busy stays high across the full conversion
	busy_hold_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.phase == ACS_CONV && s_q.cnt > 4'h1) |=> (s_q.phase == ACS_CONV))
		else $error("busy dropped early");
	// Completion sets the flag
	flag_set_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		($past(s_q.phase) == ACS_CONV && s_q.phase == ACS_IDLE && s_q.en) |-> s_q.flag)
		else $error("flag not set at completion");
	// Result captured at completion
	data_cap_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.phase == ACS_CONV && tick && s_q.cnt == 4'h1 && s_d.en) |=>
		(s_q.data == $past(sar_result_in)))
		else $error("result not stored");
	// Disabled means shutdown
	power_off_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		!s_q.en |-> (!analog_out.power_on && !analog_out.track))
		else $error("powered while disabled");
	// Reserved codes never start
	reserved_mode_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.cm > 3'h4 && s_q.phase == ACS_IDLE && !s_q.pend && !wr_ctrl) |=> !s_q.pend)
		else $error("reserved mode started");
	// Low-power start outside external mode goes through tracking
	lp_track_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.phase == ACS_IDLE && s_d.phase == ACS_TRACK) |=> (s_q.cnt == 4'h3))
		else $error("tracking length wrong");
	// Divider period
	divider_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(tick && s_q.sc == 5'h01) |=> (!tick ##1 tick))
		else $error("divider period wrong");
	// Interrupt follows enabled flag
	irq_gate_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.flag && s_q.ie) |-> irq_out)
		else $error("interrupt missing");
	// Timer 3 start latches
	tmr3_start_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.cm == 3'h1 && s_q.en && tmr3_ovf_in && s_q.phase == ACS_IDLE && !wr_ctrl)
		|=> (s_q.pend || s_q.phase != ACS_IDLE))
		else $error("timer 3 start lost");

	// Checks below watch the analog controls and the remaining start sources.
	// Each start check except the software one excludes a control write in the
	// same cycle, because such a write may disable the
	// converter, and then the start is rightly dropped.
	// Register outputs are compared with the state that they were copied from,
	// so a missed copy or a stale struct field shows up at once.

	// Converter clock pulses never come while tracking
	// A pulse with track high would sample a moving input
	track_conv_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		analog_out.sar_clk_en
		|-> !analog_out.track)
		else $error("tracking while converting");
	// Chip sleep stops tracking
	// Sleep is a level, so the next output already follows it
	sleep_track_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		sleep_in
		|=> !analog_out.track)
		else $error("tracking during sleep");
	// Channel output follows the channel register
	// A stale channel would convert the wrong input
	chan_out_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		1'b1
		|-> (analog_out.channel == s_q.chan))
		else $error("channel output stale");
	// Gain output follows the gain field
	// Code 0 is the half gain that reset leaves
	gain_out_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		1'b1
		|-> (analog_out.gain == s_q.gain))
		else $error("gain output stale");
	// Power follows the enable bit
	// Both come from the same next-state value
	power_on_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		s_q.en
		|-> analog_out.power_on)
		else $error("enabled but powered down");
	// Software busy write latches a start
	// The same write must leave the converter enabled
	sw_start_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.cm == 3'h0 && s_q.en && wr_ctrl && avs_writedata_in[`ACS_CTRL_BUSY] &&
		avs_writedata_in[`ACS_CTRL_EN] && s_q.phase == ACS_IDLE)
		|=> (s_q.pend || s_q.phase != ACS_IDLE))
		else $error("software start lost");
	// Timer 2 start latches
	// Overflow pulses last one cycle, so a miss is never retried
	tmr2_start_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.cm == 3'h3 && s_q.en && tmr2_ovf_in && s_q.phase == ACS_IDLE && !wr_ctrl)
		|=> (s_q.pend || s_q.phase != ACS_IDLE))
		else $error("timer 2 start lost");
	// External edge start latches
	// The edge is taken after the synchroniser
	ext_start_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.cm == 3'h2 && s_q.en && cnv_rise && s_q.phase == ACS_IDLE && !wr_ctrl)
		|=> (s_q.pend || s_q.phase != ACS_IDLE))
		else $error("external start lost");
	// Joint start latches
	// The other converter's busy write arrives as a one-cycle pulse
	joint_start_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.cm == 3'h4 && s_q.en && other_busy_wr_in && s_q.phase == ACS_IDLE && !wr_ctrl)
		|=> (s_q.pend || s_q.phase != ACS_IDLE))
		else $error("joint start lost");
	// Conversion loads the fixed tick count
	// The count covers at least one tick per result bit
	conv_len_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.phase != ACS_CONV && s_d.phase == ACS_CONV)
		|=> (s_q.cnt == `ACS_CONV_CLKS))
		else $error("conversion length wrong");
	// External low-power mode tracks while the pin is low
	// Conversion then starts directly on the edge
	ext_lp_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.en && s_q.tm && s_q.cm == 3'h2 && s_q.phase == ACS_IDLE && !sleep_in &&
		!s_q.cnv_sync[1] && !wr_ctrl)
		|=> analog_out.track)
		else $error("no tracking while pin low");
	// Tracking period hands over to conversion
	// Only a disabling write may cut it short
	lp_handover_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(s_q.phase == ACS_TRACK && tick && s_q.cnt == 4'h1 && s_q.en && !wr_ctrl)
		|=> (s_q.phase == ACS_CONV))
		else $error("tracking did not hand over");
	// A control read during a conversion shows busy
	// The read word is captured in the first request cycle
	busy_read_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(avs_read_in && !s_q.rd_wait && hit(avs_address_in, `ACS_OFF_CTRL) &&
		s_q.phase != ACS_IDLE)
		|=> avs_readdata_out[`ACS_CTRL_BUSY])
		else $error("busy not read back");
	// The result strobe falls on a converter tick
	// A strobe between ticks would sample an unfinished result
	sample_tick_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		analog_out.sample
		|-> analog_out.sar_clk_en)
		else $error("sample off a tick");
endmodule

// ===== logic/acs_map.svh
// Purpose: named offsets, fields, reset values and counts of the conversion sequencer
// Assumes: 32-bit Avalon-MM word addressing by byte address
// Notes: included by the top module and the testbench
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_OFF_CTRL 4'h0
`define ACS_OFF_CFG 4'h4
`define ACS_OFF_CHAN 4'h8
`define ACS_OFF_DATA 4'hc
`define ACS_CFG_RST 8'hf8
`define ACS_CTRL_EN 7
`define ACS_CTRL_TM 6
`define ACS_CTRL_INT 5
`define ACS_CTRL_BUSY 4
`define ACS_CTRL_CM_HI 2
`define ACS_CTRL_CM_LO 0
`define ACS_CTRL_IE 3
`define ACS_CFG_SC_HI 7
`define ACS_CFG_SC_LO 3
`define ACS_CFG_GN_HI 1
`define ACS_CFG_GN_LO 0
`define ACS_TRACK_CLKS 4'h3
`define ACS_CONV_CLKS 4'h8
`define ACS_RES_W 8
`endif

// ===== logic/acs_pkg.sv
// Purpose: types of the conversion sequencer
// Assumes: constants in acs_map.svh
// Notes: start codes follow the listed source order
package acs_pkg;
	// Start-of-conversion source selection
	typedef enum logic [2:0] {
		ACS_SRC_SW,
		ACS_SRC_TMR3,
		ACS_SRC_EXT,
		ACS_SRC_TMR2,
		ACS_SRC_JOINT
	} acs_src_e;
	// Sequencer phases
	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_TRACK,
		ACS_CONV
	} acs_phase_e;
	// Analog-side controls
	typedef struct packed {
		logic power_on;
		logic track;
		logic [2:0] channel;
		logic [1:0] gain;
		logic sar_clk_en;
		logic sample;
	} acs_analog_s;
	// Whole module state
	typedef struct packed {
		logic en;
		logic tm;
		logic flag;
		logic ie;
		logic [2:0] cm;
		logic [4:0] sc;
		logic [1:0] gain;
		logic [2:0] chan;
		logic [7:0] data;
		logic [4:0] div;
		logic [3:0] cnt;
		acs_phase_e phase;
		logic [1:0] cnv_sync;
		logic cnv_prev;
		logic pend;
		logic rd_wait;
		logic [31:0] rdata;
		logic irq;
		acs_analog_s ana;
	} acs_state_s;
endpackage

// ===== verification/acs_far.sv
// Purpose: far side of the sequencer: timers, convert-start pin, other converter
// Assumes: one clock; overflow and busy-write pulses last one cycle
// Notes: lat_in picks a prompt or slow answer; src 7 fires every source
`timescale 1ns/1ns
module acs_far (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Command from the bench
	input wire logic go_in,
	input wire logic [2:0] src_in,
	input wire logic [3:0] lat_in,
	// Start sources
	output logic tmr2_out,
	output logic tmr3_out,
	output logic ext_out,
	output logic obusy_out
);
	logic [3:0] wait_q; // Cycles left before firing
	logic [2:0] src_q; // Source to fire
	logic [2:0] hold_q; // Pin high time left
	logic armed_q; // A start is pending
	// Fire the chosen source, or all for src 7, after the chosen latency
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{wait_q, src_q, hold_q, armed_q} <= '0;
			{tmr2_out, tmr3_out, ext_out, obusy_out} <= '0;
		end else begin
			{tmr2_out, tmr3_out, obusy_out} <= '0;
			// Pin low between starts, one clean rising edge
			ext_out <= (hold_q != 3'h0);
			hold_q <= (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
			if (go_in) begin
				{armed_q, wait_q, src_q} <= {1'b1, lat_in, src_in};
			end else if (armed_q && wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end else if (armed_q) begin
				armed_q <= 1'b0;
				tmr3_out <= src_q == 3'h1 || src_q == 3'h7;
				hold_q <= (src_q == 3'h2 || src_q == 3'h7) ? 3'h6 : 3'h0;
				tmr2_out <= src_q == 3'h3 || src_q == 3'h7;
				obusy_out <= src_q == 3'h4 || src_q == 3'h7;
			end
		end
	end
endmodule

// ===== verification/adc_conversion_sequencer_tb.sv
// Purpose: self-checking bench of the conversion sequencer
// Assumes: reads wait one cycle, writes none
// Notes: seeded xorshift picks divider, gain, channel, result, tracking
`timescale 1ns/1ns
`include "acs_map.svh"
module adc_conversion_sequencer_tb;
	import acs_pkg::*;
	logic mclk_in = 1'b0, rstn_in = 1'b0;
	logic [3:0] addr = 4'h0, lat = 4'h0;
	logic rd_en = 1'b0, wr_en = 1'b0, go = 1'b0, sleep = 1'b0;
	logic [31:0] wdata = '0, rdata, seed, v;
	logic waitreq, irq, t2, t3, ext, obusy;
	logic [2:0] src = 3'h0;
	logic [7:0] res = 8'h00;
	acs_analog_s ana;
	int err_count = 0, comparisons = 0, ticks = 0, gap = 0, last_gap = 0, bad = 0, t0, k;
	// Free-running system clock, 40 ns
	always #20 mclk_in = ~mclk_in;
	acs_seq i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .avs_address_in(addr),
		.avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
		.avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .tmr2_ovf_in(t2),
		.tmr3_ovf_in(t3), .ext_start_in(ext), .other_busy_wr_in(obusy), .sleep_in(sleep),
		.sar_result_in(res), .analog_out(ana), .irq_out(irq));
	acs_far i_far (.clk_in(mclk_in), .rstn_in(rstn_in), .go_in(go), .src_in(src),
		.lat_in(lat), .tmr2_out(t2), .tmr3_out(t3), .ext_out(ext), .obusy_out(obusy));
	// Tick spacing, tick count, and ticks taken while tracking
	always @(posedge mclk_in) begin
		gap <= (ana.sar_clk_en === 1'b1) ? 0 : gap + 1;
		if (ana.sar_clk_en === 1'b1) begin
			last_gap <= gap + 1;
			ticks <= ticks + 1;
			bad <= bad + (ana.track !== 1'b0);
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Hold the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		{addr, wdata, wr_en, rd_en} <= {a, d, w, ~w};
		@(posedge mclk_in);
		while (waitreq !== 1'b0) @(posedge mclk_in);
		v = rdata;
		{wr_en, rd_en} <= 2'b00;
	endtask
	task automatic report_and_stop;
		$display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog well past the expected run
	initial begin
		#(40 * 60000);
		err_count++;
		report_and_stop;
	end
	initial begin
		seed = 32'd7737;
		repeat (8) @(posedge mclk_in);
		rstn_in <= 1'b1;
		bus(0, `ACS_OFF_CFG, 0);
		chk(v, `ACS_CFG_RST); // Divider and gain reset
		bus(0, `ACS_OFF_CTRL, 0);
		chk(v, 0); // Control reset, powered down
		bus(0, 4'h2, 0);
		chk(v, 0); // Unmapped address reads zero
		for (int m = 0; m < 6; m++) begin
			seed = xs(seed);
			res <= seed[15:8];
			// Divider of four or more keeps the converter clock at 5 MHz or less
			bus(1, `ACS_OFF_CFG, {24'h0, 3'h1, seed[1:0], 1'b0, seed[3:2]});
			bus(1, `ACS_OFF_CHAN, {29'h0, seed[6:4]});
			// Clear flag, then start
			bus(1, `ACS_OFF_CTRL, {24'h0, 1'b1, seed[16], 3'b001, (m < 5) ? m[2:0] : 3'h5});
			repeat (2) @(posedge mclk_in);
			chk(ana.gain, seed[3:2]); // Gain code passed on
			chk(ana.channel, seed[6:4]); // Channel passed on
			chk(ana.power_on, 1); // Enabled converter powered
			t0 = ticks;
			if (m == 0) bus(1, `ACS_OFF_CTRL, {24'h0, 1'b1, seed[16], 6'b011000});
			else begin
				{src, lat} <= {(m < 5) ? m[2:0] : 3'h7, seed[19:16]};
				go <= 1'b1;
				@(posedge mclk_in);
				go <= 1'b0;
			end
			k = 0;
			do begin
				bus(0, `ACS_OFF_CTRL, 0);
				if (m == 0 && k == 0) chk(v[4], 1); // Busy during conversion
				k++;
			end while (v[5] !== 1'b1 && k < 150);
			if (m < 5) begin
				chk(v[5:4], 2'b10); // Flag set, busy clear, each source
				chk(irq, 1); // Enabled flag interrupts
				chk(ticks - t0, `ACS_CONV_CLKS); // Fixed tick count
				chk(last_gap, seed[1:0] + 5); // Clock over divider plus one
				bus(0, `ACS_OFF_DATA, 0);
				chk(v, res); // Result stored
			end else chk(v[5], 0); // Reserved mode never starts
			$display("Test mode %0d done", m);
		end
		chk(bad, 0); // No tracking while converting
		bus(1, `ACS_OFF_CTRL, 32'h80);
		sleep <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk(ana.track, 0); // Sleep stops tracking
		sleep <= 1'b0;
		repeat (3) @(posedge mclk_in);
		chk(ana.track, 1); // Idle default mode tracks
		bus(1, `ACS_OFF_CTRL, 0);
		repeat (2) @(posedge mclk_in);
		chk(ana.power_on, 0); // Disabled is shutdown
		$display("Test power and sleep done");
		report_and_stop;
	end
endmodule
